/* File: src/macrocell_pkg.sv */
// Constants, register map and carrier types for the programmable macrocell.
// Assumes a single 10 MHz APB clock; all pins are sampled on that clock.
package macrocell_pkg;

	localparam int PAL_TERMS = 5;
	localparam int PLA_TERMS = 32;
	localparam int CT_COUNT = 6;
	localparam int CT_WIDTH = 4;

	localparam logic [11:0] CTRL_OFFSET = 12'h000;
	localparam logic [11:0] ALLOC_OFFSET = 12'h004;
	localparam logic [11:0] CT_MASK_OFFSET = 12'h008;
	localparam logic [11:0] STATUS_OFFSET = 12'h00c;

	localparam logic [1:0] OE_OFF = 2'h0;
	localparam logic [1:0] OE_ON = 2'h1;
	localparam logic [1:0] OE_TERM = 2'h2;

	localparam int CT_PRESET = 0;
	localparam int CT_RESET = 1;
	localparam int CT_OE_BASE = 2;

	localparam int STAT_FF_BIT = 0;
	localparam int STAT_PIN_BIT = 1;
	localparam int STAT_OE_BIT = 2;
	localparam int STAT_CT_LSB = 3;

	typedef struct packed {
		logic [CT_COUNT-1:0] ct_product;
		logic [4:0] eq_index;
		logic float_en;
		logic [1:0] oe_term;
		logic [1:0] oe_mode;
		logic prst_en;
		logic flex_from_eq;
		logic use_flex;
		logic falling;
		logic t_mode;
	} ctrl_t;

	localparam int CTRL_WIDTH = $bits(ctrl_t);
	localparam ctrl_t CTRL_RESET = '0;
	localparam logic [PLA_TERMS-1:0] ALLOC_RESET = 32'h0000_0000;
	localparam logic [CT_COUNT*CT_WIDTH-1:0] CT_MASK_RESET = 24'h00_0000;

	typedef enum logic [1:0] {
		AP_IDLE = 2'b01,
		AP_DONE = 2'b10
	} apb_phase_t;

	typedef struct packed {
		apb_phase_t ph;
		ctrl_t ctrl;
		logic [PLA_TERMS-1:0] alloc;
		logic [CT_COUNT-1:0][CT_WIDTH-1:0] ct_mask;
		logic [CT_COUNT-1:0] ct_val;
		logic prim_q;
		logic flex_q;
		logic ff;
		logic pin_fb;
		logic oe;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} state_t;

endpackage

/* File: src/programmable_macrocell.sv */
// One macrocell with its I/O cell, configured over APB.
// Clock pins are plain inputs sampled on pclk; their edges are detected here.
`timescale 1ns/100ps
`default_nettype none

module programmable_macrocell
	import macrocell_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic primary_sync_clock,
	input wire logic secondary_flex_clock,
	input wire logic [PAL_TERMS-1:0] pal_terms,
	input wire logic [PLA_TERMS-1:0] pla_terms,
	input wire logic [CT_COUNT-1:0][CT_WIDTH-1:0] ct_literals,
	input wire logic global_float_pin,
	input wire logic pin_in,
	output logic pin_out,
	output logic pin_oe,
	output logic macrocell_feedback,
	output logic pin_feedback
);

	state_t s_reg;
	state_t s_next;
	logic mc_in;
	logic flex_lvl;
	logic clk_cur;
	logic clk_prev;
	logic clk_edge;
	logic [CT_COUNT-1:0] ct;
	logic oe_calc;
	logic acc;
	logic hit_ctrl;
	logic hit_alloc;
	logic hit_mask;
	logic hit_stat;

	// Sum or product of the literals a control term selects
	function automatic logic ct_eval(
		input logic [CT_WIDTH-1:0] lits,
		input logic [CT_WIDTH-1:0] mask,
		input logic product
	);
		logic r;
		if (product) begin
			r = &(lits | ~mask);
		end else begin
			r = |(lits & mask);
		end
		return r;
	endfunction

	function automatic logic edge_hit(
		input logic cur,
		input logic prev,
		input logic falling
	);
		return falling ? (prev & ~cur) : (cur & ~prev);
	endfunction

	always_comb begin
		s_next = s_reg;
		mc_in = (|pal_terms) | (|(pla_terms & s_reg.alloc));
		for (int i = 0; i < CT_COUNT; i++) begin
			ct[i] = ct_eval(ct_literals[i], s_reg.ct_mask[i],
				s_reg.ctrl.ct_product[i]);
		end
		s_next.ct_val = ct;

		// Second clock from its pin or from an equation term
		flex_lvl = s_reg.ctrl.flex_from_eq ?
			pla_terms[s_reg.ctrl.eq_index] : secondary_flex_clock;
		s_next.prim_q = primary_sync_clock;
		s_next.flex_q = flex_lvl;
		clk_cur = s_reg.ctrl.use_flex ? flex_lvl : primary_sync_clock;
		clk_prev = s_reg.ctrl.use_flex ? s_reg.flex_q : s_reg.prim_q;
		clk_edge = edge_hit(clk_cur, clk_prev, s_reg.ctrl.falling);

		if (clk_edge) begin
			if (s_reg.ctrl.t_mode) begin
				s_next.ff = s_reg.ff ^ mc_in;
			end else begin
				s_next.ff = mc_in;
			end
		end
		// Preset/reset override any clock edge; reset wins over preset
		if (s_reg.ctrl.prst_en) begin
			if (ct[CT_RESET]) begin
				s_next.ff = 1'b0;
			end else if (ct[CT_PRESET]) begin
				s_next.ff = 1'b1;
			end
		end

		unique case (s_reg.ctrl.oe_mode)
			OE_OFF: oe_calc = 1'b0;
			OE_ON: oe_calc = 1'b1;
			OE_TERM: oe_calc = ct[CT_OE_BASE + 32'(s_reg.ctrl.oe_term)];
			default: oe_calc = 1'b0;
		endcase
		if (s_reg.ctrl.float_en && !global_float_pin) begin
			oe_calc = 1'b0;
		end
		s_next.oe = oe_calc;
		s_next.pin_fb = pin_in;

		// APB slave: one wait state, response registered
		acc = psel & penable;
		hit_ctrl = (paddr == CTRL_OFFSET);
		hit_alloc = (paddr == ALLOC_OFFSET);
		hit_mask = (paddr == CT_MASK_OFFSET);
		hit_stat = (paddr == STATUS_OFFSET);
		unique case (s_reg.ph)
			AP_IDLE: begin
				if (acc) begin
					s_next.ph = AP_DONE;
					s_next.pready = 1'b1;
					s_next.pslverr = ~(hit_ctrl | hit_alloc | hit_mask |
						(hit_stat & ~pwrite));
					s_next.prdata = 32'h0000_0000;
					if (!pwrite) begin
						if (hit_ctrl) begin
							s_next.prdata[CTRL_WIDTH-1:0] = s_reg.ctrl;
						end else if (hit_alloc) begin
							s_next.prdata = s_reg.alloc;
						end else if (hit_mask) begin
							s_next.prdata[CT_COUNT*CT_WIDTH-1:0] = s_reg.ct_mask;
						end else if (hit_stat) begin
							s_next.prdata[STAT_FF_BIT] = s_reg.ff;
							s_next.prdata[STAT_PIN_BIT] = s_reg.pin_fb;
							s_next.prdata[STAT_OE_BIT] = s_reg.oe;
							s_next.prdata[STAT_CT_LSB +: CT_COUNT] = s_reg.ct_val;
						end
					end
				end
			end
			AP_DONE: begin
				s_next.ph = AP_IDLE;
				s_next.pready = 1'b0;
				s_next.pslverr = 1'b0;
				if (acc && pwrite) begin
					if (hit_ctrl) begin
						s_next.ctrl = ctrl_t'(pwdata[CTRL_WIDTH-1:0]);
					end else if (hit_alloc) begin
						s_next.alloc = pwdata;
					end else if (hit_mask) begin
						s_next.ct_mask = pwdata[CT_COUNT*CT_WIDTH-1:0];
					end
				end
			end
			default: begin
				s_next.ph = AP_IDLE;
				s_next.pready = 1'b0;
				s_next.pslverr = 1'b0;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_reg.ph <= AP_IDLE;
			s_reg.ctrl <= CTRL_RESET;
			s_reg.alloc <= ALLOC_RESET;
			s_reg.ct_mask <= CT_MASK_RESET;
			s_reg.ct_val <= '0;
			s_reg.prim_q <= 1'b0;
			s_reg.flex_q <= 1'b0;
			s_reg.ff <= 1'b0;
			s_reg.pin_fb <= 1'b0;
			s_reg.oe <= 1'b0;
			s_reg.prdata <= 32'h0000_0000;
			s_reg.pready <= 1'b0;
			s_reg.pslverr <= 1'b0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign prdata = s_reg.prdata;
	assign pready = s_reg.pready;
	assign pslverr = s_reg.pslverr;
	assign pin_out = s_reg.ff;
	assign pin_oe = s_reg.oe;
	assign macrocell_feedback = s_reg.ff;
	assign pin_feedback = s_reg.pin_fb;

endmodule

`default_nettype wire

/* File: tb/board_model.sv */
// Board side of the I/O pin: a second driver plus a pull-up.
// Assumes pin_oe is high while the macrocell drives the pin.
`timescale 1ns/100ps
`default_nettype none
module board_model (
	input wire logic pin_out,
	input wire logic pin_oe,
	input wire logic ext_en,
	input wire logic ext_val,
	output logic pin_in
);
	// Released pin floats high; two drivers at once give an unknown
	assign pin_in = pin_oe ? (ext_en ? 1'hx : pin_out)
		: (ext_en ? ext_val : 1'h1);
endmodule
`default_nettype wire

/* File: tb/macrocell_chk.sv */
// Checker on the macrocell's top-level ports, bound below.
// Assumes the single clock pclk and async active-low presetn.
`timescale 1ns/100ps
`default_nettype none
module macrocell_chk (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic pin_in,
	input wire logic pin_out,
	input wire logic pin_oe,
	input wire logic macrocell_feedback,
	input wire logic pin_feedback
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	AST_WAIT: assert property (psel && penable && !pready |=> pready)
		else $error("late pready");
	AST_PULSE: assert property (pready |=> !pready) else $error("long pready");
	AST_REQ: assert property (pready |-> psel && penable) else $error("stray");
	AST_ERR: assert property (pslverr |-> pready && (pwrite || !prdata))
		else $error("bad error answer");
	AST_FB: assert property (macrocell_feedback == pin_out)
		else $error("feedback differs");
	AST_PIN_FB: assert property ($past(presetn) |->
		pin_feedback == $past(pin_in)) else $error("pin feedback");
	AST_OWN: assert property (pin_oe && $past(pin_oe) |->
		pin_feedback == $past(pin_out)) else $error("own value lost");
	AST_RST: assert property ($rose(presetn) |-> !pin_out && !pin_oe)
		else $error("not clear after reset");
	cover property (pslverr);
	cover property ($rose(pin_out));
	cover property ($fell(pin_oe));
endmodule
bind programmable_macrocell macrocell_chk chk_u (.*);
`default_nettype wire

/* File: tb/tb_programmable_macrocell.sv */
// Bench for the macrocell: APB tasks, clock-pin pulses, pin checks.
// Assumes the package, checker and board model compile first.
`timescale 1ns/100ps
`default_nettype none
module tb_programmable_macrocell;
	logic pclk = '0, presetn = '0, psel = '0, penable = '0, pwrite = '0;
	logic global_float_pin = '1, ext_en = '0, ext_val = '0, er;
	logic pready, pslverr, pin_in, pin_out, pin_oe;
	logic macrocell_feedback, pin_feedback;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rd;
	logic [33:0] drv = '0;
	logic [4:0] pal = '0;
	logic [23:0] lits = '0;
	// Steps: control word, clock pin, term inputs, expected levels
	logic [31:0] ck[10] = '{32'h103, 32'h10100, 32'h10000, 32'h10103,
		32'h20002, 32'h40100, 32'h41103, 32'h140c1003, 32'h140c7000,
		32'h203};
	logic [31:0] pt[6] = '{32'h100010, 32'h100102, 32'h100012,
		32'h80100001, 32'h80100103, 32'h80000110};
	int fails = 0, samples_checked = 0;
	programmable_macrocell dut_u (.*, .primary_sync_clock(drv[0]),
		.secondary_flex_clock(drv[1]), .pal_terms(pal),
		.pla_terms(drv[33:2]), .ct_literals(lits));
	board_model board_u (.*);
	initial forever #50 pclk = ~pclk;
	task stop_test;
		$display("checks %0d fails %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		{psel, pwrite, paddr, pwdata} <= {1'h1, w, a, d};
		@(posedge pclk);
		penable <= '1;
		for (int n = 0; pready !== 1'h1; n++) begin
			if (n == 20) begin
				fails++;
				stop_test;
			end
			@(posedge pclk);
		end
		rd = prdata;
		er = pslverr;
		psel <= '0;
		penable <= '0;
	endtask
	task pulse(input int i, input logic [1:0] e);
		for (int h = 1; h >= 0; h--) begin
			@(posedge pclk);
			drv[i] <= h[0];
			repeat (2) @(posedge pclk);
			chk("flip_flop", e[h], pin_out);
		end
	endtask
	initial begin
		repeat (12) @(posedge pclk);
		presetn <= '1;
		chk("pin_out", '0, pin_out);
		apb('1, 12'h4, 32'h200);
		apb('0, 12'h0, '0);
		chk("ctrl", '0, rd);
		apb('0, 12'h10, '0);
		chk("unmapped", 32'h1, rd | er);
		apb('1, 12'hc, '1);
		chk("status_wr", 32'h1, er);
		for (int k = 0; k < 10; k++) begin
			apb('1, 12'h0, {16'h0, ck[k][31:16]});
			pal[2] <= ck[k][8];
			drv[11] <= ck[k][9];
			pulse(ck[k][15:12], ck[k][1:0]);
		end
		apb('1, 12'h8, 32'h111113);
		for (int k = 0; k < 6; k++) begin
			apb('1, 12'h0, {16'h0, pt[k][31:16]});
			lits <= {16'h0, pt[k][7:0]};
			repeat (2) @(posedge pclk);
			chk("preset_reset", pt[k][8], pin_out);
		end
		apb('1, 12'h0, 32'h220);
		repeat (2) @(posedge pclk);
		chk("oe_on", 32'h3, {pin_oe, pin_in});
		global_float_pin <= '0;
		repeat (2) @(posedge pclk);
		chk("oe_float", '0, pin_oe);
		global_float_pin <= '1;
		for (int t = 0; t < 4; t++) begin
			apb('1, 12'h0, 32'h40 | (t << 7));
			lits <= 24'h1 << (8 + 4 * t);
			repeat (2) @(posedge pclk);
			chk("oe_term", 32'h1, pin_oe);
			lits <= 24'h111100 ^ (24'h1 << (8 + 4 * t));
			repeat (2) @(posedge pclk);
			chk("oe_term", '0, pin_oe);
		end
		apb('1, 12'h0, '0);
		repeat (2) @(posedge pclk);
		ext_en <= '1;
		apb('0, 12'hc, '0);
		chk("status", 32'he1, rd[8:0]);
		chk("pin_feedback", '0, pin_feedback);
		chk("macrocell_feedback", 32'h1, macrocell_feedback);
		// Second reset in mid-run with the flip-flop set
		presetn <= '0;
		repeat (2) @(posedge pclk);
		presetn <= '1;
		chk("pin_out_rst", '0, pin_out);
		apb('0, 12'h0, '0);
		chk("ctrl_rst", '0, rd);
		chk("ff_rst", '0, macrocell_feedback);
		stop_test;
	end
endmodule
`default_nettype wire
